/* File: ssr_addr_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module ssr_addr_gen #(
  parameter int unsigned VA_BITS = 48
) (
  // Address parts
  input  wire logic [63:0] seg_base_i,
  input  wire logic [63:0] base_i,
  input  wire logic [63:0] index_i,
  input  wire logic [1:0]  scale_i,
  input  wire logic [63:0] disp_i,
  input  wire logic        wide_i,
  // Results
  output logic      [63:0] offset_o,
  output logic      [63:0] lin_o,
  output logic             canon_o
);
  logic [63:0] sum;

  always_comb
  begin
    sum = base_i + (index_i << scale_i) + disp_i;
    if (wide_i)
    begin
      // Free wrap across the sign boundary
      offset_o = sum;
      lin_o    = seg_base_i + sum;
      canon_o  = ssr_pkg::canonical(lin_o, VA_BITS);
    end
    else
    begin
      // Upper base half plays no part here
      offset_o = {32'h0, sum[31:0]};
      lin_o    = {32'h0, seg_base_i[31:0] + sum[31:0]};
      canon_o  = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: ssr_pkg.sv */
package ssr_pkg;
  localparam int          NSEG          = 6;
  localparam logic [2:0]  SEG_EXTRA     = 3'h0;
  localparam logic [2:0]  SEG_CODE      = 3'h1;
  localparam logic [2:0]  SEG_STACK     = 3'h2;
  localparam logic [2:0]  SEG_DATA      = 3'h3;
  localparam logic [2:0]  SEG_FIRST     = 3'h4;
  localparam logic [2:0]  SEG_SECOND    = 3'h5;
  localparam logic [2:0]  TGT_LOCAL_TBL = 3'h6;
  localparam int          SEL_IDX_HI    = 15;
  localparam int          SEL_IDX_LO    = 3;
  localparam int          SEL_TBL       = 2;
  localparam int          SEL_RQP_HI    = 1;
  localparam int          SEL_RQP_LO    = 0;
  localparam int          DESC_SHIFT    = 3;
  localparam logic [31:0] MREG_FIRST    = 32'hc000_0100;
  localparam logic [31:0] MREG_SECOND   = 32'hc000_0101;
  localparam int          ATTR_DPRV_HI  = 6;
  localparam int          ATTR_DPRV_LO  = 5;
  localparam int          ATTR_LONG     = 1;
  localparam int          ATTR_DSIZE    = 0;
  localparam logic [1:0]  PRIV_KERNEL   = 2'h0;
  localparam logic [1:0]  PRIV_USER     = 2'h3;
  localparam logic [15:0] RST_SEL       = 16'h0000;
  localparam logic [1:0]  RST_PRIV      = 2'h0;

  typedef enum logic [1:0] {
    ACC_DATA    = 2'h0,
    ACC_STR_DST = 2'h1,
    ACC_STACK   = 2'h2,
    ACC_FETCH   = 2'h3
  } ssr_acc_e;

  // Upper bits from va_bits-1 up must all match bit 63
  function automatic logic canonical(input logic [63:0] a, input int unsigned va_bits);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      if ((i >= int'(va_bits) - 1) && (a[i] != a[63]))
        ok = 1'b0;
    end
    return ok;
  endfunction
endpackage

/* File: ssr_sel_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module ssr_sel_decode (
  // Selector in, entry address out
  ssr_sel_if.dec s
);
  logic [12:0] idx;

  always_comb
  begin
    idx         = s.sel[ssr_pkg::SEL_IDX_HI:ssr_pkg::SEL_IDX_LO];
    s.tbl_local = s.sel[ssr_pkg::SEL_TBL];
    s.rqp       = s.sel[ssr_pkg::SEL_RQP_HI:ssr_pkg::SEL_RQP_LO];
    // Privilege bits take no part in the null test
    s.is_null   = (idx == 13'h0) && !s.tbl_local;
    // Index scaled by eight even where an entry spans two slots
    s.desc_addr = (s.tbl_local ? s.loc_base : s.gbl_base)
                + (64'(idx) << ssr_pkg::DESC_SHIFT);
  end
endmodule
`default_nettype wire

/* File: ssr_sel_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ssr_sel_if;
  logic [15:0] sel;
  logic [63:0] gbl_base;
  logic [63:0] loc_base;
  logic [63:0] desc_addr;
  logic        is_null;
  logic        tbl_local;
  logic [1:0]  rqp;
  modport dec  (input sel, gbl_base, loc_base, output desc_addr, is_null, tbl_local, rqp);
  modport user (output sel, gbl_base, loc_base, input desc_addr, is_null, tbl_local, rqp);
endinterface
`default_nettype wire

/* File: ssr_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module ssr_unit #(
  parameter int unsigned VA_BITS = 48
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Mode
  input  wire logic        mode64_i,
  // Table bases
  input  wire logic [63:0] gbl_table_base_i,
  input  wire logic [63:0] loc_table_base_i,
  // Segment load
  input  wire logic        load_req_i,
  input  wire logic [2:0]  load_tgt_i,
  input  wire logic [15:0] load_sel_i,
  output logic             busy_o,
  output logic             load_done_o,
  // Descriptor fetch
  output logic             desc_req_o,
  output logic      [63:0] desc_addr_o,
  input  wire logic        desc_valid_i,
  input  wire logic [31:0] desc_base_i,
  input  wire logic [31:0] desc_limit_i,
  input  wire logic [7:0]  desc_attr_i,
  // Memory access
  input  wire logic        acc_req_i,
  input  wire logic [1:0]  acc_kind_i,
  input  wire logic        acc_ovr_i,
  input  wire logic [2:0]  acc_ovr_seg_i,
  input  wire logic [63:0] acc_base_i,
  input  wire logic [63:0] acc_index_i,
  input  wire logic [1:0]  acc_scale_i,
  input  wire logic [63:0] acc_disp_i,
  output logic             acc_done_o,
  output logic      [63:0] lin_addr_o,
  output logic             cs_long_o,
  output logic             cs_dsize_o,
  // Model register port
  input  wire logic        mreg_wr_i,
  input  wire logic        mreg_rd_i,
  input  wire logic [31:0] mreg_addr_i,
  input  wire logic [63:0] mreg_wdata_i,
  output logic             mreg_ack_o,
  output logic      [63:0] mreg_rdata_o,
  // Status
  input  wire logic [2:0]  sel_rd_tgt_i,
  output logic      [15:0] sel_rd_data_o,
  output logic      [1:0]  running_privilege_o,
  output logic             prot_fault_o
);
  localparam int NS = ssr_pkg::NSEG;

  typedef enum logic {
    SSR_IDLE  = 1'b0,
    SSR_FETCH = 1'b1
  } ssr_st_e;

  typedef struct packed {
    ssr_st_e                st;
    logic [2:0]             tgt;
    logic [15:0]            sel_hold;
    logic [NS-1:0][15:0]    sel;
    logic [NS-1:0][63:0]    base;
    logic [NS-1:0][31:0]    limit;
    logic [NS-1:0][7:0]     attr;
    logic [NS-1:0]          live;
    logic [15:0]            loc_sel;
    logic [1:0]             priv;
    logic                   busy;
    logic                   load_done;
    logic                   desc_req;
    logic [63:0]            desc_addr;
    logic                   acc_done;
    logic [63:0]            lin;
    logic                   mreg_ack;
    logic [63:0]            mreg_rdata;
    logic [15:0]            sel_rd;
    logic                   fault;
  } ssr_state_s;

  function automatic logic [2:0] seg_pick(input ssr_pkg::ssr_acc_e k, input logic ovr,
                                          input logic [2:0] os);
    logic [2:0] s;
    s = ssr_pkg::SEG_DATA;
    if (k == ssr_pkg::ACC_FETCH)
      s = ssr_pkg::SEG_CODE;
    else if (ovr)
      s = os;
    else if (k == ssr_pkg::ACC_STR_DST)
      s = ssr_pkg::SEG_EXTRA;
    else if (k == ssr_pkg::ACC_STACK)
      s = ssr_pkg::SEG_STACK;
    return s;
  endfunction

  ssr_state_s  r;
  ssr_state_s  n;
  logic [2:0]  acc_seg;
  logic        acc_in;
  logic [63:0] cur_base;
  logic [31:0] cur_limit;
  logic        cur_live;
  logic [63:0] ag_seg_base;
  logic [63:0] ag_off;
  logic [63:0] ag_lin;
  logic        ag_canon;
  logic [1:0]  desc_priv;
  logic [1:0]  rqp_hold;
  logic [1:0]  eff_priv;
  logic        priv_bad;
  logic        hit_first;
  logic        hit_second;

  ssr_sel_if sd ();

  assign sd.sel      = load_sel_i;
  assign sd.gbl_base = gbl_table_base_i;
  assign sd.loc_base = loc_table_base_i;

  ssr_sel_decode u_dec (
    .s (sd)
  );

  ssr_addr_gen #(
    .VA_BITS (VA_BITS)
  ) u_ag (
    .seg_base_i (ag_seg_base),
    .base_i     (acc_base_i),
    .index_i    (acc_index_i),
    .scale_i    (acc_scale_i),
    .disp_i     (acc_disp_i),
    .wide_i     (mode64_i),
    .offset_o   (ag_off),
    .lin_o      (ag_lin),
    .canon_o    (ag_canon)
  );

  always_comb
  begin
    acc_seg   = seg_pick(ssr_pkg::ssr_acc_e'(acc_kind_i), acc_ovr_i, acc_ovr_seg_i);
    acc_in    = (acc_seg <= ssr_pkg::SEG_SECOND);
    cur_base  = 64'h0;
    cur_limit = 32'h0;
    cur_live  = 1'b0;
    for (int i = 0; i < NS; i++)
    begin
      if (acc_seg == 3'(i))
      begin
        cur_base  = r.base[i];
        cur_limit = r.limit[i];
        cur_live  = r.live[i];
      end
    end
    // Only first and second extra keep a base in 64-bit mode
    if (mode64_i && (acc_seg != ssr_pkg::SEG_FIRST) && (acc_seg != ssr_pkg::SEG_SECOND))
      ag_seg_base = 64'h0;
    else
      ag_seg_base = cur_base;
    desc_priv  = desc_attr_i[ssr_pkg::ATTR_DPRV_HI:ssr_pkg::ATTR_DPRV_LO];
    rqp_hold   = r.sel_hold[ssr_pkg::SEL_RQP_HI:ssr_pkg::SEL_RQP_LO];
    eff_priv   = (rqp_hold > r.priv) ? rqp_hold : r.priv;
    // Stack needs exact match, data needs enough privilege
    if (r.tgt == ssr_pkg::SEG_STACK)
      priv_bad = (rqp_hold != r.priv) || (desc_priv != r.priv);
    else if (r.tgt == ssr_pkg::SEG_CODE)
      priv_bad = 1'b0;
    else
      priv_bad = (eff_priv > desc_priv);
    hit_first  = (mreg_addr_i == ssr_pkg::MREG_FIRST);
    hit_second = (mreg_addr_i == ssr_pkg::MREG_SECOND);
  end

  always_comb
  begin
    n           = r;
    n.load_done = 1'b0;
    n.desc_req  = 1'b0;
    n.acc_done  = 1'b0;
    n.mreg_ack  = 1'b0;
    n.fault     = 1'b0;
    n.sel_rd    = (sel_rd_tgt_i == ssr_pkg::TGT_LOCAL_TBL) ? r.loc_sel : 16'h0;
    for (int i = 0; i < NS; i++)
    begin
      if (sel_rd_tgt_i == 3'(i))
        n.sel_rd = r.sel[i];
    end
    // Registers change only through loads and base writes, never with mode
    unique case (r.st)
      SSR_IDLE:
      begin
        if (load_req_i)
        begin
          n.tgt      = load_tgt_i;
          n.sel_hold = load_sel_i;
          if ((load_tgt_i > ssr_pkg::TGT_LOCAL_TBL) ||
              ((load_tgt_i == ssr_pkg::TGT_LOCAL_TBL) && sd.tbl_local && !sd.is_null))
          begin
            n.fault     = 1'b1;
            n.load_done = 1'b1;
          end
          else if (sd.is_null)
          begin
            n.load_done = 1'b1;
            if ((load_tgt_i == ssr_pkg::SEG_CODE) ||
                ((load_tgt_i == ssr_pkg::SEG_STACK) &&
                 (!mode64_i || (r.priv == ssr_pkg::PRIV_USER))))
              n.fault = 1'b1;
            else if (load_tgt_i == ssr_pkg::TGT_LOCAL_TBL)
              n.loc_sel = load_sel_i;
            else
            begin
              for (int i = 0; i < NS; i++)
              begin
                if (load_tgt_i == 3'(i))
                begin
                  n.sel[i]  = load_sel_i;
                  n.live[i] = 1'b0;
                end
              end
            end
          end
          else
          begin
            n.st        = SSR_FETCH;
            n.busy      = 1'b1;
            n.desc_req  = 1'b1;
            n.desc_addr = sd.desc_addr;
          end
        end
      end
      SSR_FETCH:
      begin
        if (desc_valid_i)
        begin
          n.st        = SSR_IDLE;
          n.busy      = 1'b0;
          n.load_done = 1'b1;
          if (r.tgt == ssr_pkg::TGT_LOCAL_TBL)
            n.loc_sel = r.sel_hold;
          else if (priv_bad)
            n.fault = 1'b1;
          else
          begin
            for (int i = 0; i < NS; i++)
            begin
              if (r.tgt == 3'(i))
              begin
                n.sel[i]   = r.sel_hold;
                n.base[i]  = {32'h0, desc_base_i};
                n.limit[i] = desc_limit_i;
                n.attr[i]  = desc_attr_i;
                n.live[i]  = 1'b1;
              end
            end
            if (r.tgt == ssr_pkg::SEG_CODE)
              n.priv = desc_priv;
          end
        end
      end
    endcase
    if (acc_req_i)
    begin
      n.acc_done = 1'b1;
      n.lin      = ag_lin;
      if (!acc_in)
        n.fault = 1'b1;
      else if (mode64_i)
      begin
        if (!ag_canon)
          n.fault = 1'b1;
      end
      else if (!cur_live || (ag_off > {32'h0, cur_limit}))
        n.fault = 1'b1;
    end
    if (mreg_wr_i || mreg_rd_i)
    begin
      n.mreg_ack   = 1'b1;
      n.mreg_rdata = hit_first  ? r.base[ssr_pkg::SEG_FIRST]  :
                     hit_second ? r.base[ssr_pkg::SEG_SECOND] : 64'h0;
      if ((hit_first || hit_second) && (r.priv != ssr_pkg::PRIV_KERNEL))
        n.fault = 1'b1;
      else if (mreg_wr_i && (hit_first || hit_second))
      begin
        if (!ssr_pkg::canonical(mreg_wdata_i, VA_BITS))
          n.fault = 1'b1;
        else if (hit_first)
          n.base[ssr_pkg::SEG_FIRST] = mreg_wdata_i;
        else
          n.base[ssr_pkg::SEG_SECOND] = mreg_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      r         <= ssr_state_s'('0);
      r.sel     <= {NS{ssr_pkg::RST_SEL}};
      r.loc_sel <= ssr_pkg::RST_SEL;
      r.priv    <= ssr_pkg::RST_PRIV;
    end
    else
      r <= n;
  end

  assign busy_o              = r.busy;
  assign load_done_o         = r.load_done;
  assign desc_req_o          = r.desc_req;
  assign desc_addr_o         = r.desc_addr;
  assign acc_done_o          = r.acc_done;
  assign lin_addr_o          = r.lin;
  assign cs_long_o           = r.attr[ssr_pkg::SEG_CODE][ssr_pkg::ATTR_LONG];
  assign cs_dsize_o          = r.attr[ssr_pkg::SEG_CODE][ssr_pkg::ATTR_DSIZE];
  assign mreg_ack_o          = r.mreg_ack;
  assign mreg_rdata_o        = r.mreg_rdata;
  assign sel_rd_data_o       = r.sel_rd;
  assign running_privilege_o = r.priv;
  assign prot_fault_o        = r.fault;

  logic [63:0]         exp_addr;
  logic [63:0]         first_base;
  logic [NS-1:0][15:0] sel_all;

  assign exp_addr   = (load_sel_i[2] ? loc_table_base_i : gbl_table_base_i)
                    + {48'h0, load_sel_i[15:3], 3'h0};
  assign first_base = r.base[ssr_pkg::SEG_FIRST];
  assign sel_all    = r.sel;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_desc_addr_form: assert property (
    load_req_i && !busy_o && !sd.is_null && (load_tgt_i < ssr_pkg::TGT_LOCAL_TBL)
    |=> desc_req_o && busy_o && (desc_addr_o == $past(exp_addr)))
    else $error("descriptor address not formed from selector");
  a_null_code_load: assert property (
    load_req_i && !busy_o && sd.is_null && (load_tgt_i == ssr_pkg::SEG_CODE)
    |=> prot_fault_o && load_done_o && !desc_req_o)
    else $error("null code load did not fault");
  a_null_stack_ok: assert property (
    load_req_i && !busy_o && sd.is_null && (load_tgt_i == ssr_pkg::SEG_STACK) && mode64_i &&
    (running_privilege_o != ssr_pkg::PRIV_USER) && !acc_req_i && !mreg_wr_i && !mreg_rd_i
    |=> !prot_fault_o && load_done_o ##1 !busy_o)
    else $error("null stack load in 64-bit mode faulted");
  a_code_priv_set: assert property (
    (r.st == SSR_FETCH) && desc_valid_i && (r.tgt == ssr_pkg::SEG_CODE)
    |=> (running_privilege_o == $past(desc_priv)) && load_done_o && !busy_o)
    else $error("running privilege not taken from code descriptor");
  a_null_use_fault: assert property (
    acc_req_i && !mode64_i && acc_in && !cur_live |=> prot_fault_o && acc_done_o)
    else $error("use of null segment did not fault");
  a_wide_base_zero: assert property (
    acc_req_i && mode64_i && !acc_ovr_i && (acc_kind_i != 2'h3)
    |=> lin_addr_o == $past(ag_off))
    else $error("64-bit data base not treated as zero");
  a_compat_upper: assert property (
    acc_req_i && !mode64_i |=> lin_addr_o[63:32] == 32'h0)
    else $error("compatibility address has upper bits");
  a_load_upper_clr: assert property (
    (r.st == SSR_FETCH) && desc_valid_i && (r.tgt == ssr_pkg::SEG_FIRST) && !priv_bad &&
    !mreg_wr_i |=> first_base == {32'h0, $past(desc_base_i)})
    else $error("selector load left upper base bits");
  a_mreg_priv_fault: assert property (
    mreg_wr_i && hit_first && (running_privilege_o != ssr_pkg::PRIV_KERNEL)
    |=> prot_fault_o && mreg_ack_o && (first_base == $past(first_base)))
    else $error("unprivileged base write not refused");
  a_sel_stable: assert property (
    (r.st == SSR_IDLE) && !load_req_i ##1 !load_req_i
    |-> $stable(sel_all) ##1 $stable(sel_all))
    else $error("selectors changed without a load");

  c_fetch_load:  cover property (desc_req_o ##[1:20] load_done_o && !prot_fault_o);
  c_null_data:   cover property (load_req_i && sd.is_null && (load_tgt_i == ssr_pkg::SEG_DATA));
  c_mreg_write:  cover property (mreg_wr_i && hit_second ##1 !prot_fault_o);
  c_access_flt:  cover property (acc_req_i ##1 prot_fault_o);
endmodule
`default_nettype wire

/* File: ssr_unit_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ssr_unit_tb_top;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, mode64_i = 1'b0;
  logic        load_req_i = 1'b0, desc_valid_i = 1'b0, acc_req_i = 1'b0;
  logic        acc_ovr_i = 1'b0, mreg_wr_i = 1'b0, mreg_rd_i = 1'b0;
  logic [2:0]  load_tgt_i = 3'h0, acc_ovr_seg_i = 3'h0, sel_rd_tgt_i = 3'h0;
  logic [1:0]  acc_kind_i = 2'h0, acc_scale_i = 2'h0;
  logic [15:0] load_sel_i = 16'h0;
  logic [31:0] desc_base_i = 32'h0, desc_limit_i = 32'h0, mreg_addr_i = 32'h0;
  logic [7:0]  desc_attr_i = 8'h0;
  logic [63:0] acc_base_i = 64'h0, acc_index_i = 64'h0, acc_disp_i = 64'h0;
  logic [63:0] mreg_wdata_i = 64'h0;
  logic [63:0] gbl_table_base_i = 64'h10_0000, loc_table_base_i = 64'h20_0000;
  logic        busy_o, load_done_o, desc_req_o, acc_done_o, cs_long_o, cs_dsize_o;
  logic        mreg_ack_o, prot_fault_o;
  logic [63:0] desc_addr_o, lin_addr_o, mreg_rdata_o;
  logic [15:0] sel_rd_data_o;
  logic [1:0]  running_privilege_o;
  int          num_errors = 0, samples_checked = 0;
  localparam logic [63:0] FSB = 64'hffff_8000_0000_0000;

  ssr_unit u_ssr_unit (
    .sys_clk_i           (sys_clk_i),
    .rst_n_i             (rst_n_i),
    .mode64_i            (mode64_i),
    .gbl_table_base_i    (gbl_table_base_i),
    .loc_table_base_i    (loc_table_base_i),
    .load_req_i          (load_req_i),
    .load_tgt_i          (load_tgt_i),
    .load_sel_i          (load_sel_i),
    .busy_o              (busy_o),
    .load_done_o         (load_done_o),
    .desc_req_o          (desc_req_o),
    .desc_addr_o         (desc_addr_o),
    .desc_valid_i        (desc_valid_i),
    .desc_base_i         (desc_base_i),
    .desc_limit_i        (desc_limit_i),
    .desc_attr_i         (desc_attr_i),
    .acc_req_i           (acc_req_i),
    .acc_kind_i          (acc_kind_i),
    .acc_ovr_i           (acc_ovr_i),
    .acc_ovr_seg_i       (acc_ovr_seg_i),
    .acc_base_i          (acc_base_i),
    .acc_index_i         (acc_index_i),
    .acc_scale_i         (acc_scale_i),
    .acc_disp_i          (acc_disp_i),
    .acc_done_o          (acc_done_o),
    .lin_addr_o          (lin_addr_o),
    .cs_long_o           (cs_long_o),
    .cs_dsize_o          (cs_dsize_o),
    .mreg_wr_i           (mreg_wr_i),
    .mreg_rd_i           (mreg_rd_i),
    .mreg_addr_i         (mreg_addr_i),
    .mreg_wdata_i        (mreg_wdata_i),
    .mreg_ack_o          (mreg_ack_o),
    .mreg_rdata_o        (mreg_rdata_o),
    .sel_rd_tgt_i        (sel_rd_tgt_i),
    .sel_rd_data_o       (sel_rd_data_o),
    .running_privilege_o (running_privilege_o),
    .prot_fault_o        (prot_fault_o)
  );

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Load; exp_da of zero means no descriptor fetch is expected
  task automatic ld(input logic [2:0] t, input logic [15:0] s, input logic [63:0] exp_da,
                    input logic [31:0] b, input logic [7:0] at, input logic ef);
    logic flt;
    @(negedge sys_clk_i);
    load_req_i = 1'b1;
    load_tgt_i = t;
    load_sel_i = s;
    @(negedge sys_clk_i);
    load_req_i = 1'b0;
    flt = prot_fault_o;
    chk(64'(desc_req_o), 64'(exp_da != 64'h0));
    chk(64'(busy_o), 64'(exp_da != 64'h0));
    if (desc_req_o === 1'b1)
    begin
      chk(desc_addr_o, exp_da);
      desc_valid_i = 1'b1;
      desc_base_i = b;
      desc_limit_i = 32'hffff;
      desc_attr_i = at;
      @(negedge sys_clk_i);
      desc_valid_i = 1'b0;
      flt = prot_fault_o;
    end
    chk(64'(load_done_o), 64'h1);
    chk(64'(busy_o), 64'h0);
    chk(64'(flt), 64'(ef));
  endtask

  task automatic ac(input logic [1:0] k, input logic ov, input logic [2:0] sg,
                    input logic [63:0] b, input logic [63:0] x, input logic [1:0] sc,
                    input logic [63:0] d, input logic [63:0] el, input logic ef);
    @(negedge sys_clk_i);
    acc_req_i = 1'b1;
    acc_kind_i = k;
    acc_ovr_i = ov;
    acc_ovr_seg_i = sg;
    acc_base_i = b;
    acc_index_i = x;
    acc_scale_i = sc;
    acc_disp_i = d;
    @(negedge sys_clk_i);
    acc_req_i = 1'b0;
    chk(64'(acc_done_o), 64'h1);
    chk(64'(prot_fault_o), 64'(ef));
    if (!ef)
      chk(lin_addr_o, el);
  endtask

  task automatic mr(input logic w, input logic [31:0] a, input logic [63:0] wd,
                    input logic [63:0] ed, input logic ef);
    @(negedge sys_clk_i);
    mreg_wr_i = w;
    mreg_rd_i = !w;
    mreg_addr_i = a;
    mreg_wdata_i = wd;
    @(negedge sys_clk_i);
    mreg_wr_i = 1'b0;
    mreg_rd_i = 1'b0;
    chk(64'(mreg_ack_o), 64'h1);
    chk(64'(prot_fault_o), 64'(ef));
    if (!w && !ef)
      chk(mreg_rdata_o, ed);
  endtask

  task automatic sr(input logic [2:0] t, input logic [15:0] e);
    @(negedge sys_clk_i);
    sel_rd_tgt_i = t;
    @(negedge sys_clk_i);
    chk(64'(sel_rd_data_o), 64'(e));
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++)
      sr(3'(i), 16'h0);
    chk(64'(running_privilege_o), 64'h0);
    ac(2'h0, 1'b0, 3'h0, 64'h10, 64'h0, 2'h0, 64'h0, 64'h0, 1'b1);
  endtask

  task automatic t_null();
    ld(3'h3, 16'h0003, 64'h0, 32'h0, 8'h0, 1'b0);
    sr(3'h3, 16'h0003);
    ld(3'h1, 16'h0000, 64'h0, 32'h0, 8'h0, 1'b1);
    ld(3'h2, 16'h0000, 64'h0, 32'h0, 8'h0, 1'b1);
    ld(3'h7, 16'h0000, 64'h0, 32'h0, 8'h0, 1'b1);
    mode64_i = 1'b1;
    ld(3'h2, 16'h0000, 64'h0, 32'h0, 8'h0, 1'b0);
    ac(2'h0, 1'b0, 3'h0, 64'h10, 64'h0, 2'h0, 64'h0, 64'h10, 1'b0);
  endtask

  task automatic t_fetch();
    mode64_i = 1'b0;
    ld(3'h3, 16'h000c, 64'h20_0008, 32'h1000, 8'h0, 1'b0);
    ac(2'h0, 1'b0, 3'h0, 64'h20, 64'h0, 2'h0, 64'h0, 64'h1020, 1'b0);
    ac(2'h0, 1'b0, 3'h0, 64'h1_0000, 64'h0, 2'h0, 64'h0, 64'h0, 1'b1);
    ac(2'h1, 1'b0, 3'h0, 64'h20, 64'h0, 2'h0, 64'h0, 64'h0, 1'b1);
    ac(2'h2, 1'b0, 3'h0, 64'h20, 64'h0, 2'h0, 64'h0, 64'h0, 1'b1);
  endtask

  task automatic t_first();
    ld(3'h4, 16'h0010, 64'h10_0010, 32'h2000, 8'h0, 1'b0);
    mr(1'b1, ssr_pkg::MREG_FIRST, FSB, 64'h0, 1'b0);
    mr(1'b0, ssr_pkg::MREG_FIRST, 64'h0, FSB, 1'b0);
    ac(2'h0, 1'b1, 3'h4, 64'h30, 64'h0, 2'h0, 64'h0, 64'h30, 1'b0);
    mode64_i = 1'b1;
    ac(2'h0, 1'b1, 3'h4, 64'h10, 64'h2, 2'h3, 64'h100, FSB + 64'h120, 1'b0);
    ac(2'h0, 1'b1, 3'h4, 64'h0, 64'h0, 2'h0, 64'h8000_0000_0000, 64'h0, 1'b0);
    ac(2'h0, 1'b1, 3'h4, 64'h0, 64'h0, 2'h0, 64'h1_0000_0000_0000, 64'h0, 1'b1);
    ac(2'h0, 1'b0, 3'h0, 64'h1000, 64'h0, 2'h0, 64'h0, 64'h1000, 1'b0);
    ac(2'h0, 1'b0, 3'h0, 64'h0, 64'h0, 2'h0, 64'h8000_0000_0000, 64'h0, 1'b1);
    ac(2'h3, 1'b0, 3'h0, 64'h40, 64'h0, 2'h0, 64'h0, 64'h40, 1'b0);
    mr(1'b1, ssr_pkg::MREG_SECOND, 64'h1234, 64'h0, 1'b0);
    mr(1'b0, ssr_pkg::MREG_SECOND, 64'h0, 64'h1234, 1'b0);
    mr(1'b1, ssr_pkg::MREG_FIRST, 64'h1_0000_0000_0000, 64'h0, 1'b1);
    mr(1'b0, ssr_pkg::MREG_FIRST, 64'h0, FSB, 1'b0);
    mr(1'b0, 32'hc000_0102, 64'h0, 64'h0, 1'b0);
    ld(3'h4, 16'h0028, 64'h10_0028, 32'h3000, 8'h0, 1'b0);
    mr(1'b0, ssr_pkg::MREG_FIRST, 64'h0, 64'h3000, 1'b0);
  endtask

  task automatic t_mode();
    mode64_i = 1'b0;
    sr(3'h3, 16'h000c);
    ac(2'h0, 1'b0, 3'h0, 64'h20, 64'h0, 2'h0, 64'h0, 64'h1020, 1'b0);
  endtask

  task automatic t_priv();
    ld(3'h1, 16'h001b, 64'h10_0018, 32'h0, 8'h63, 1'b0);
    chk(64'(running_privilege_o), 64'h3);
    chk(64'({cs_long_o, cs_dsize_o}), 64'h3);
    mr(1'b1, ssr_pkg::MREG_FIRST, 64'h0, 64'h0, 1'b1);
    ld(3'h3, 16'h000c, 64'h20_0008, 32'h5000, 8'h0, 1'b1);
    ac(2'h0, 1'b0, 3'h0, 64'h20, 64'h0, 2'h0, 64'h0, 64'h1020, 1'b0);
    mode64_i = 1'b1;
    ld(3'h2, 16'h0000, 64'h0, 32'h0, 8'h0, 1'b1);
  endtask

  initial
  begin
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    t_reset();
    t_null();
    t_fetch();
    t_first();
    t_mode();
    t_priv();
    summarize();
  end
endmodule
`default_nettype wire
